// [rtl/pio_pkg.sv]
// constants, register map and state type of the point i/o acquisition loop
// assumes a 32-bit classic wishbone master and a 100 MHz system clock
package pio_pkg;
  typedef enum logic [1:0] {PIO_INIT, PIO_WAIT, PIO_RUN} pio_state_t;

  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned N_SLOTS     = 7;
  localparam int unsigned N_AO        = 3;
  localparam int unsigned N_AUX       = 2;
  localparam int unsigned ADR_W       = 8;
  // sampling period in ns; count derived from the clock rate
  localparam int unsigned PERIOD_NS   = 10_000;
  localparam int unsigned PERIOD_CYC  = PERIOD_NS / (1_000_000_000 / CLK_HZ);

  // byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATE   = 8'h04;
  localparam logic [7:0] A_STATUS  = 8'h08;
  localparam logic [7:0] A_PERIOD  = 8'h0c;
  localparam logic [7:0] A_AO0     = 8'h10;
  localparam logic [7:0] A_AI0     = 8'h20;
  localparam logic [7:0] A_DOUT    = 8'h30;
  localparam logic [7:0] A_DIN     = 8'h34;
  localparam logic [7:0] A_INTERNAL_LOOP_DRIVEN_BIT   = 8'h38;
  localparam logic [7:0] A_INTERNAL_LOOP_SENSED_BIT   = 8'h3c;
  localparam logic [7:0] A_AUXAO0  = 8'h40;
  localparam logic [7:0] A_AUXAI0  = 8'h48;
  localparam logic [7:0] A_STEP    = 8'h04;

  // control register fields
  localparam int unsigned B_RUN    = 0;
  localparam int unsigned B_DEBUG  = 1;
  localparam int unsigned B_AOEN   = 4;
endpackage

// [rtl/pio_loop.sv]
// point i/o acquisition loop: sequencer, sample timer, i/o paths, register slave
// assumes module pins are asynchronous; converter words arrive on clk_sys
`timescale 1ns/1ps
`default_nettype none
module pio_loop #(
  parameter int unsigned FXP_W      = 16,
  parameter int unsigned PERIOD_RST = pio_pkg::PERIOD_CYC
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [pio_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // module presence and health, one bit per slot
  input  wire logic [pio_pkg::N_SLOTS-1:0] slot_present_i,
  input  wire logic [pio_pkg::N_SLOTS-1:0] slot_ok_i,
  // analog output module
  output logic [pio_pkg::N_AO-1:0][FXP_W-1:0] ao_code_o,
  output logic [pio_pkg::N_AO-1:0]            ao_load_o,
  // analog input module, same clock domain
  input  wire logic [pio_pkg::N_AO-1:0][FXP_W-1:0] ai_code_i,
  output logic                                     ai_convert_o,
  // digital modules
  output logic                           ttl_ch0_o,
  output logic                           ttl_ch0_oe_n_o,
  input  wire logic                      ttl_ch4_i,
  output logic                           sink_ch0_o,
  input  wire logic                      src_in_ch0_i,
  output logic                           src_ch0_o,
  input  wire logic                      sink_in_ch0_i
);
  localparam int unsigned NS = pio_pkg::N_SLOTS;
  localparam int unsigned NA = pio_pkg::N_AO;
  localparam int unsigned NX = pio_pkg::N_AUX;
  localparam int unsigned NP = 2 * NS + 3;

  pio_pkg::pio_state_t state;

  // host-written controls
  logic                     run_request;
  logic                     debug_mode;
  logic [NA-1:0]            analog_out_enable;
  logic [31:0]              period;
  logic signed [31:0]       analog_out_value [NA];
  logic [2:0]               driven_level;
  logic [NX-1:0]            internal_loop_driven_bit;
  logic signed [31:0]       internal_loop_out_word [NX];
  // indicators
  logic signed [31:0]       sampled_input_word [NA];
  logic [2:0]               sensed_level;
  logic [NX-1:0]            internal_loop_sensed_bit;
  logic signed [31:0]       internal_loop_in_word [NX];
  logic                     init_done;

  // pin synchronisers, three stages, change taken when stages two and three agree
  logic [NP-1:0] pin_s1;
  logic [NP-1:0] pin_s2;
  logic [NP-1:0] pin_s3;
  logic [NP-1:0] pin_f;
  logic [NS-1:0] present_f;
  logic [NS-1:0] ok_f;
  logic          ttl_ch4_f;
  logic          src_in_f;
  logic          sink_in_f;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= {sink_in_ch0_i, src_in_ch0_i, ttl_ch4_i, slot_ok_i, slot_present_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_filt
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pin_f[gp] <= 1'b0;
        end else if (pin_s2[gp] == pin_s3[gp]) begin
          pin_f[gp] <= pin_s3[gp];
        end
      end
    end
  endgenerate

  assign present_f = pin_f[NS-1:0];
  assign ok_f      = pin_f[2*NS-1:NS];
  assign ttl_ch4_f = pin_f[2*NS];
  assign src_in_f  = pin_f[2*NS+1];
  assign sink_in_f = pin_f[2*NS+2];

  // fixed slot map: every slot must hold its module and report healthy
  logic modules_ok;
  assign modules_ok = &present_f && &ok_f;

  // sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= pio_pkg::PIO_INIT;
    end else begin
      unique case (state)
        pio_pkg::PIO_INIT: if (modules_ok) state <= pio_pkg::PIO_WAIT;
        pio_pkg::PIO_WAIT: begin
          if (!modules_ok) state <= pio_pkg::PIO_INIT;
          else if (run_request && init_done) state <= pio_pkg::PIO_RUN;
        end
        pio_pkg::PIO_RUN:  if (!run_request) state <= pio_pkg::PIO_INIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) init_done <= 1'b0;
    else init_done <= (state == pio_pkg::PIO_INIT) ? modules_ok : init_done && modules_ok;
  end

  // sample timer: a period of zero behaves as one cycle
  logic [31:0] tick_cnt;
  logic        tick;
  assign tick = (state == pio_pkg::PIO_RUN) && (tick_cnt == '0);

  always_ff @(posedge clk_sys) begin
    if (rst || state != pio_pkg::PIO_RUN) tick_cnt <= '0;
    else if (tick_cnt == '0) tick_cnt <= (period == '0) ? '0 : period - 32'h1;
    else tick_cnt <= tick_cnt - 32'h1;
  end

  // saturating conversion to the module's fixed point word
  localparam logic signed [31:0] FXP_MAX = 32'sd1 <<< (FXP_W - 1);
  function automatic logic [FXP_W-1:0] to_fxp(input logic signed [31:0] v);
    if (v >= FXP_MAX) to_fxp = {1'b0, {(FXP_W-1){1'b1}}};
    else if (v < -FXP_MAX) to_fxp = {1'b1, {(FXP_W-1){1'b0}}};
    else to_fxp = v[FXP_W-1:0];
  endfunction

  // analog output and input paths
  genvar ga;
  generate
    for (ga = 0; ga < NA; ga++) begin : g_ao
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          ao_code_o[ga] <= '0;
          ao_load_o[ga] <= 1'b0;
        end else begin
          ao_load_o[ga] <= tick && analog_out_enable[ga];
          if (tick && analog_out_enable[ga]) ao_code_o[ga] <= to_fxp(analog_out_value[ga]);
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) sampled_input_word[ga] <= '0;
        else if (tick && !debug_mode)
          sampled_input_word[ga] <= 32'(signed'(ai_code_i[ga]));
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) ai_convert_o <= 1'b0;
    else ai_convert_o <= tick && !debug_mode;
  end

  // digital paths, refreshed once per sample
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ttl_ch0_o      <= 1'b0;
      ttl_ch0_oe_n_o <= 1'b1;
      sink_ch0_o     <= 1'b0;
      src_ch0_o      <= 1'b0;
      sensed_level   <= '0;
    end else begin
      ttl_ch0_oe_n_o <= 1'b0;
      if (tick) begin
        ttl_ch0_o    <= driven_level[0];
        sink_ch0_o   <= driven_level[1];
        src_ch0_o    <= driven_level[2];
        sensed_level <= {sink_in_f, src_in_f, ttl_ch4_f};
      end
    end
  end

  // internal loopback terminals, never reach a pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      internal_loop_sensed_bit <= '0;
      internal_loop_in_word    <= '{default: '0};
    end else begin
      internal_loop_sensed_bit <= internal_loop_driven_bit;
      internal_loop_in_word    <= internal_loop_out_word;
    end
  end

  // wishbone slave: ack one cycle after the strobe, dropped the next cycle
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] next_rdata;
  logic [7:0]  adr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;
  assign adr    = {wb_adr_i[7:2], 2'b00};

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) if (s[b]) merge[8*b +: 8] = n[8*b +: 8];
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] ctrl_merged;
  assign ctrl_word   = {25'h0, analog_out_enable, 2'b00, debug_mode, run_request};
  assign ctrl_merged = merge(ctrl_word, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_request       <= 1'b0;
      debug_mode        <= 1'b0;
      analog_out_enable <= '0;
    end else if (wb_wr && adr == pio_pkg::A_CTRL) begin
      run_request       <= ctrl_merged[pio_pkg::B_RUN];
      debug_mode        <= ctrl_merged[pio_pkg::B_DEBUG];
      analog_out_enable <= ctrl_merged[pio_pkg::B_AOEN +: NA];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      period                   <= PERIOD_RST;
      driven_level             <= '0;
      internal_loop_driven_bit <= '0;
    end else if (wb_wr) begin
      if (adr == pio_pkg::A_PERIOD) period <= merge(period, wb_dat_i, wb_sel_i);
      if (adr == pio_pkg::A_DOUT && wb_sel_i[0]) driven_level <= wb_dat_i[2:0];
      if (adr == pio_pkg::A_INTERNAL_LOOP_DRIVEN_BIT && wb_sel_i[0])
        internal_loop_driven_bit <= wb_dat_i[NX-1:0];
    end
  end

  genvar gw;
  generate
    for (gw = 0; gw < NA; gw++) begin : g_aow
      always_ff @(posedge clk_sys) begin
        if (rst) analog_out_value[gw] <= '0;
        else if (wb_wr && adr == pio_pkg::A_AO0 + 8'(gw) * pio_pkg::A_STEP)
          analog_out_value[gw] <= merge(analog_out_value[gw], wb_dat_i, wb_sel_i);
      end
    end
    for (gw = 0; gw < NX; gw++) begin : g_auxw
      always_ff @(posedge clk_sys) begin
        if (rst) internal_loop_out_word[gw] <= '0;
        else if (wb_wr && adr == pio_pkg::A_AUXAO0 + 8'(gw) * pio_pkg::A_STEP)
          internal_loop_out_word[gw] <= merge(internal_loop_out_word[gw], wb_dat_i, wb_sel_i);
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero and are still acknowledged
  always_comb begin
    next_rdata = '0;
    unique case (adr)
      pio_pkg::A_CTRL:   next_rdata = ctrl_word;
      pio_pkg::A_STATE:  next_rdata = 32'(state);
      pio_pkg::A_STATUS: next_rdata = {30'h0, modules_ok, init_done};
      pio_pkg::A_PERIOD: next_rdata = period;
      pio_pkg::A_DOUT:   next_rdata = {29'h0, driven_level};
      pio_pkg::A_DIN:    next_rdata = {29'h0, sensed_level};
      pio_pkg::A_INTERNAL_LOOP_DRIVEN_BIT:  next_rdata = 32'(internal_loop_driven_bit);
      pio_pkg::A_INTERNAL_LOOP_SENSED_BIT:  next_rdata = 32'(internal_loop_sensed_bit);
      default: begin
        for (int i = 0; i < NA; i++) begin
          if (adr == pio_pkg::A_AO0 + 8'(i) * pio_pkg::A_STEP) next_rdata = analog_out_value[i];
          if (adr == pio_pkg::A_AI0 + 8'(i) * pio_pkg::A_STEP) next_rdata = sampled_input_word[i];
        end
        for (int i = 0; i < NX; i++) begin
          if (adr == pio_pkg::A_AUXAO0 + 8'(i) * pio_pkg::A_STEP)
            next_rdata = internal_loop_out_word[i];
          if (adr == pio_pkg::A_AUXAI0 + 8'(i) * pio_pkg::A_STEP)
            next_rdata = internal_loop_in_word[i];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) wb_dat_o <= next_rdata;
    end
  end

  // checks
  property p_init_hold;
    @(posedge clk_sys) disable iff (rst)
      state == pio_pkg::PIO_INIT && !modules_ok |=> state == pio_pkg::PIO_INIT;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("left init without modules");

  property p_wait_idle;
    @(posedge clk_sys) disable iff (rst)
      state == pio_pkg::PIO_WAIT && !run_request |=> state != pio_pkg::PIO_RUN;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("run entered without request");

  property p_stop;
    @(posedge clk_sys) disable iff (rst)
      state == pio_pkg::PIO_RUN && !run_request |=> state == pio_pkg::PIO_INIT;
  endproperty
  a_stop: assert property (p_stop) else $error("run did not return to init");

  property p_start;
    @(posedge clk_sys) disable iff (rst)
      state == pio_pkg::PIO_WAIT && run_request && init_done && modules_ok
      |=> state == pio_pkg::PIO_RUN;
  endproperty
  a_start: assert property (p_start) else $error("run request not honoured");

  property p_tick_space;
    @(posedge clk_sys) disable iff (rst)
      tick && period == 32'h4 && $stable(period) |=> !tick [*3] ##1 (tick || !run_request);
  endproperty
  a_tick_space: assert property (p_tick_space) else $error("sample period wrong");

  property p_ao_drive;
    @(posedge clk_sys) disable iff (rst)
      tick && analog_out_enable[0] |=> ao_load_o[0] && ao_code_o[0] == to_fxp($past(analog_out_value[0]));
  endproperty
  a_ao_drive: assert property (p_ao_drive) else $error("analog output not driven");

  property p_ao_off;
    @(posedge clk_sys) disable iff (rst)
      !analog_out_enable[1] |=> !ao_load_o[1] && $stable(ao_code_o[1]);
  endproperty
  a_ao_off: assert property (p_ao_off) else $error("disabled output changed");

  property p_debug;
    @(posedge clk_sys) disable iff (rst)
      debug_mode |=> $stable(sampled_input_word[0]) && !ai_convert_o;
  endproperty
  a_debug: assert property (p_debug) else $error("acquired in debug mode");

  property p_ai_conv;
    @(posedge clk_sys) disable iff (rst)
      tick && !debug_mode |=> sampled_input_word[2] == 32'(signed'($past(ai_code_i[2])));
  endproperty
  a_ai_conv: assert property (p_ai_conv) else $error("input conversion wrong");

  property p_dig;
    @(posedge clk_sys) disable iff (rst)
      tick |=> ttl_ch0_o == $past(driven_level[0]) && src_ch0_o == $past(driven_level[2])
               && sensed_level[1] == $past(src_in_f);
  endproperty
  a_dig: assert property (p_dig) else $error("digital path wrong");

  property p_loop;
    @(posedge clk_sys) disable iff (rst)
      ##1 internal_loop_sensed_bit == $past(internal_loop_driven_bit)
          && internal_loop_in_word[1] == $past(internal_loop_out_word[1]);
  endproperty
  a_loop: assert property (p_loop) else $error("internal loop broken");

  property p_state_read;
    @(posedge clk_sys) disable iff (rst)
      wb_req && !wb_we_i && adr == pio_pkg::A_STATE |=> wb_ack_o && wb_dat_o == 32'($past(state));
  endproperty
  a_state_read: assert property (p_state_read) else $error("state readback wrong");

  c_run:   cover property (@(posedge clk_sys) disable iff (rst)
                           state == pio_pkg::PIO_WAIT ##1 state == pio_pkg::PIO_RUN);
  c_stop:  cover property (@(posedge clk_sys) disable iff (rst)
                           state == pio_pkg::PIO_RUN ##1 state == pio_pkg::PIO_INIT);
  c_tick2: cover property (@(posedge clk_sys) disable iff (rst) tick ##[1:20] tick);
  c_write: cover property (@(posedge clk_sys) disable iff (rst) wb_wr ##1 wb_ack_o);
endmodule // pio_loop
`default_nettype wire

// [testbench/pio_io_model.sv]
// model of the plug-in i/o modules wired to the acquisition loop pins
// assumes the loop's pin names; converter codes change only on a load pulse
`timescale 1ns/1ps
`default_nettype none
module pio_io_model (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // fault injection from the bench
  input  wire logic [pio_pkg::N_SLOTS-1:0]   slot_missing,
  input  wire logic [pio_pkg::N_SLOTS-1:0]   slot_faulty,
  // slot status pins
  output logic      [pio_pkg::N_SLOTS-1:0]   slot_present_i,
  output logic      [pio_pkg::N_SLOTS-1:0]   slot_ok_i,
  // analog modules
  input  wire logic [2:0][15:0]              ao_code_o,
  input  wire logic [2:0]                    ao_load_o,
  output logic      [2:0][15:0]              ai_code_i,
  // digital modules
  input  wire logic                          ttl_ch0_o,
  input  wire logic                          ttl_ch0_oe_n_o,
  output logic                               ttl_ch4_i,
  input  wire logic                          sink_ch0_o,
  output logic                               src_in_ch0_i,
  input  wire logic                          src_ch0_o,
  output logic                               sink_in_ch0_i
);
  logic [2:0][15:0] held;
  logic             ttl_last;

  // fixed slot allocation: one status bit per slot
  assign slot_present_i = ~slot_missing;
  assign slot_ok_i      = ~slot_faulty;

  // analog output codes held on their load pulse and fed back to inputs, channel for channel
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        held[i] <= 16'h0000;
      end else if (ao_load_o[i]) begin
        held[i] <= ao_code_o[i];
      end
    end
  end
  assign ai_code_i = held;

  // an undriven ttl line floats: show the opposite of its last level
  always_ff @(posedge clk_sys) ttl_last <= rst ? 1'b0 : ttl_ch4_i;
  assign ttl_ch4_i     = ttl_ch0_oe_n_o ? ~ttl_last : ttl_ch0_o;
  assign src_in_ch0_i  = sink_ch0_o;
  assign sink_in_ch0_i = src_ch0_o;
endmodule // pio_io_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the point i/o acquisition loop
// assumes a classic wishbone slave answering with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]       wb_adr_i = 8'h00;
  logic [3:0]       wb_sel_i = 4'h0;
  logic [31:0]      wb_dat_i = 32'h0, wb_dat_o, rd;
  logic             wb_ack_o;
  logic [6:0]       slot_present_i, slot_ok_i;
  logic [6:0]       slot_missing = 7'h40, slot_faulty = 7'h00;
  logic [2:0][15:0] ao_code_o, ai_code_i;
  logic [2:0]       ao_load_o;
  logic             ai_convert_o, ttl_ch0_o, ttl_ch0_oe_n_o, ttl_ch4_i;
  logic             sink_ch0_o, src_in_ch0_i, src_ch0_o, sink_in_ch0_i;
  int               fail_count = 0, num_checks = 0, conv_count = 0;

  // short period keeps the run brief
  pio_loop #(.FXP_W(16), .PERIOD_RST(4)) dut (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slot_present_i(slot_present_i),
    .slot_ok_i(slot_ok_i), .ao_code_o(ao_code_o), .ao_load_o(ao_load_o),
    .ai_code_i(ai_code_i), .ai_convert_o(ai_convert_o), .ttl_ch0_o(ttl_ch0_o),
    .ttl_ch0_oe_n_o(ttl_ch0_oe_n_o), .ttl_ch4_i(ttl_ch4_i), .sink_ch0_o(sink_ch0_o),
    .src_in_ch0_i(src_in_ch0_i), .src_ch0_o(src_ch0_o), .sink_in_ch0_i(sink_in_ch0_i));

  pio_io_model modules (
    .clk_sys(clk_sys), .rst(rst), .slot_missing(slot_missing), .slot_faulty(slot_faulty),
    .slot_present_i(slot_present_i), .slot_ok_i(slot_ok_i), .ao_code_o(ao_code_o),
    .ao_load_o(ao_load_o), .ai_code_i(ai_code_i), .ttl_ch0_o(ttl_ch0_o),
    .ttl_ch0_oe_n_o(ttl_ch0_oe_n_o), .ttl_ch4_i(ttl_ch4_i), .sink_ch0_o(sink_ch0_o),
    .src_in_ch0_i(src_in_ch0_i), .src_ch0_o(src_ch0_o), .sink_in_ch0_i(sink_in_ch0_i));

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (ai_convert_o === 1'b1) conv_count++;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until the rising edge that samples ack high
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t no bus answer", $time);
      close_out();
    end
    // data taken and request released at the very edge that saw ack
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic wait_state(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      bus(1'b0, pio_pkg::A_STATE, 32'h0);
      n++;
    end while (rd !== e && n < 50);
    check(rd, e);
  endtask

  initial begin
    int c;
    repeat (5) @(posedge clk_sys);
    check({31'h0, ttl_ch0_oe_n_o}, 32'h1);
    rst <= 1'b0;
    rd_chk(pio_pkg::A_STATE, 32'h0);
    rd_chk(pio_pkg::A_PERIOD, 32'h4);
    repeat (20) @(posedge clk_sys);
    rd_chk(pio_pkg::A_STATE, 32'h0);
    rd_chk(pio_pkg::A_STATUS, 32'h0);
    check({31'h0, ttl_ch0_oe_n_o}, 32'h0);
    slot_missing <= 7'h00;
    slot_faulty  <= 7'h04;
    repeat (20) @(posedge clk_sys);
    rd_chk(pio_pkg::A_STATE, 32'h0);
    slot_faulty <= 7'h00;
    wait_state(32'h1);
    rd_chk(pio_pkg::A_STATUS, 32'h3);
    c = conv_count;
    repeat (20) @(posedge clk_sys);
    rd_chk(pio_pkg::A_STATE, 32'h1);
    check(conv_count - c, 32'h0);
    slot_missing <= 7'h02;
    wait_state(32'h0);
    slot_missing <= 7'h00;
    wait_state(32'h1);
    // internal loop terminals, no pins involved
    wr(pio_pkg::A_INTERNAL_LOOP_DRIVEN_BIT, 32'h2);
    wr(pio_pkg::A_AUXAO0, 32'hdeadbeef);
    wr(pio_pkg::A_AUXAO0 + 8'h04, 32'h80000001);
    rd_chk(pio_pkg::A_INTERNAL_LOOP_SENSED_BIT, 32'h2);
    rd_chk(pio_pkg::A_AUXAI0, 32'hdeadbeef);
    rd_chk(pio_pkg::A_AUXAI0 + 8'h04, 32'h80000001);
    wr(8'hfc, 32'hffffffff);
    rd_chk(8'hfc, 32'h0);
    wr(pio_pkg::A_AO0, 32'h00001234);
    wr(pio_pkg::A_AO0 + 8'h04, 32'hfffffffb);
    wr(pio_pkg::A_AO0 + 8'h08, 32'h00012345);
    wr(pio_pkg::A_DOUT, 32'h3);
    wr(pio_pkg::A_CTRL, 32'h31);
    wait_state(32'h2);
    repeat (12) @(posedge clk_sys);
    check({16'h0, ao_code_o[0]}, 32'h1234);
    check({16'h0, ao_code_o[1]}, 32'hfffb);
    check({16'h0, ao_code_o[2]}, 32'h0);
    check({29'h0, src_ch0_o, sink_ch0_o, ttl_ch0_o}, 32'h3);
    rd_chk(pio_pkg::A_AI0, 32'h00001234);
    rd_chk(pio_pkg::A_AI0 + 8'h04, 32'hfffffffb);
    rd_chk(pio_pkg::A_AI0 + 8'h08, 32'h0);
    rd_chk(pio_pkg::A_DIN, 32'h3);
    c = conv_count;
    repeat (40) @(posedge clk_sys);
    check(conv_count - c, 32'd10);
    // shorter period written in mid-run; old countdown ends first
    wr(pio_pkg::A_PERIOD, 32'h2);
    repeat (4) @(posedge clk_sys);
    c = conv_count;
    repeat (20) @(posedge clk_sys);
    check(conv_count - c, 32'd10);
    wr(pio_pkg::A_PERIOD, 32'h4);
    rd_chk(pio_pkg::A_PERIOD, 32'h4);
    wr(pio_pkg::A_CTRL, 32'h33);
    wr(pio_pkg::A_AO0, 32'h00000042);
    repeat (2) @(posedge clk_sys);
    c = conv_count;
    repeat (20) @(posedge clk_sys);
    check(conv_count - c, 32'h0);
    check({16'h0, ao_code_o[0]}, 32'h0042);
    rd_chk(pio_pkg::A_AI0, 32'h00001234);
    wr(pio_pkg::A_CTRL, 32'h71);
    repeat (12) @(posedge clk_sys);
    check({16'h0, ao_code_o[2]}, 32'h7fff);
    rd_chk(pio_pkg::A_AI0 + 8'h08, 32'h00007fff);
    rd_chk(pio_pkg::A_AI0, 32'h00000042);
    // module loss in the loop is not watched; only the run request stops it
    slot_missing <= 7'h01;
    repeat (20) @(posedge clk_sys);
    rd_chk(pio_pkg::A_STATE, 32'h2);
    wr(pio_pkg::A_CTRL, 32'h0);
    rd_chk(pio_pkg::A_STATE, 32'h0);
    slot_missing <= 7'h00;
    wait_state(32'h1);
    close_out();
  end
endmodule // testbench
`default_nettype wire
